/* File: pkg/irq_pkg.sv */
// Constants, types and the register map of the interrupt routing block.
// Assumes a single pclk domain that also serves as the PCI clock of the serial link.
package irq_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_EVT_FLAG = 8'h00;
  localparam logic [7:0] OFF_EVT_MASK = 8'h04;
  localparam logic [7:0] OFF_EVT_CLR = 8'h08;
  localparam logic [7:0] OFF_MISC = 8'h0C;
  localparam logic [7:0] OFF_CARD_FLAG = 8'h10;
  localparam logic [7:0] OFF_CARD_CLR = 8'h14;
  localparam logic [7:0] OFF_CARD_MASK = 8'h18;
  localparam logic [7:0] OFF_SER_STAT = 8'h1C;

  // ==========================================================
  // fields and reset values
  localparam int MISC_SER_EN_BIT = 29;
  localparam int MISC_LINK_SEL_BIT = 1;
  localparam int MISC_CARD_SEL_BIT = 25;
  localparam logic [31:0] MISC_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam int CARD_EVT_W = 3;

  // ==========================================================
  // serial link timing, in PCI clocks
  localparam logic [3:0] START_MIN = 4'h4;
  localparam logic [3:0] START_MAX = 4'h8;
  localparam logic [3:0] STOP_QUIET = 4'h2;
  localparam logic [3:0] STOP_CONT = 4'h3;
  localparam logic [5:0] FRAME_INTA = 6'h11;
  localparam logic [5:0] FRAME_INTB = 6'h12;
  localparam logic [5:0] FRAME_LAST = 6'h3F;

  // ==========================================================
  // types
  typedef struct packed {
    logic insert;
    logic remove;
    logic error;
  } irq_card_evt_t;

  typedef struct packed {
    logic ser_en;
    logic card_sel;
    logic link_sel;
  } irq_route_t;

  typedef enum logic [1:0] {SER_IDLE, SER_START_DRV, SER_START_WAIT, SER_FRAMES} irq_ser_state_t;
  typedef enum logic [1:0] {PH_S, PH_R, PH_T} irq_phase_t;
  typedef enum logic {MODE_CONT, MODE_QUIET} irq_mode_t;

endpackage

/* File: src/irq_flag_bank.sv */
// Bank of sticky event flags: hardware sets, software clears by writing ones.
// Assumes set and clear are single-cycle pulses in the pclk domain.
`timescale 1ns/10ps
module irq_flag_bank
  import irq_pkg::*;
#(
  parameter int W = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // set and clear pulses
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // flag state
  output logic [W-1:0] flag_reg
);

  // ==========================================================
  // flags
  // a set in the same cycle as its clear wins, so no event is lost
  // clear by write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= (flag_reg & ~clr) | set;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_set_wins_clear: assert property (##1 ((flag_reg & $past(set)) == $past(set)))
    else $error("set event lost");
  a_clear_takes_flag: assert property (##1 ((flag_reg & $past(clr & ~set)) == '0))
    else $error("cleared flag still set");

endmodule

/* File: src/irq_pulse_meter.sv */
// Measures how many clocks the serial line stays low.
// Assumes the line input is already synchronous to pclk.
`timescale 1ns/10ps
module irq_pulse_meter
  import irq_pkg::*;
#(
  parameter int CW = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // observed line level
  input wire logic line_in,
  // measurement
  output logic [CW-1:0] low_cnt_reg,
  output logic pulse_end,
  output logic [CW-1:0] pulse_width
);

  // ==========================================================
  // low counter, saturating so very long pulses stay out of range
  // widths in clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_reg <= '0;
    end else if (line_in) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != '1) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end

  assign pulse_end = line_in && (low_cnt_reg != '0);
  assign pulse_width = low_cnt_reg;

endmodule

/* File: src/irq_top.sv */
// Interrupt routing and serialized IRQ engine with an APB register port.
// Assumes all pins are synchronous to pclk, which is also the PCI clock,
// and that the external wire resolves the open-drain enables.
`timescale 1ns/10ps
module irq_top
  import irq_pkg::*;
#(
  parameter int LINK_W = 32,
  parameter int N_CARDS = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt sources
  input wire logic [LINK_W-1:0] link_evt,
  input wire irq_card_evt_t [N_CARDS-1:0] card_evt,
  // pci interrupt pins
  input wire logic inta_in,
  output logic inta_out,
  output logic inta_oe_n,
  input wire logic intb_in,
  output logic intb_out,
  output logic intb_oe_n,
  // serial line on multiuse pin zero
  input wire logic serial_irq_in,
  output logic serial_irq_out,
  output logic serial_irq_oe_n,
  // pin function selects
  output logic multiuse_pin_zero_serial,
  output logic gpio_enable,
  output logic activity_led_zero_enable
);

  localparam int CARD_W = N_CARDS * CARD_EVT_W;

  logic [31:0] mask_reg;
  logic [CARD_W-1:0] card_mask_reg;
  irq_route_t route_reg;
  logic [LINK_W-1:0] event_flag_reg;
  logic [CARD_W-1:0] card_flag_reg;
  logic [LINK_W-1:0] evt_clr;
  logic [CARD_W-1:0] card_clr;
  logic access, done, wr;
  logic link_pend, card_pend, line_a, line_b;
  irq_ser_state_t state_reg, state_next;
  irq_phase_t phase_reg, phase_next;
  irq_mode_t mode_reg, mode_next;
  logic [5:0] frame_reg, frame_next;
  logic [1:0] sent_reg;
  logic ser_req, own_pend, drv_low_next, drv_high_next;
  logic [3:0] low_cnt, pulse_width;
  logic pulse_end, start_ok;
  logic [31:0] rd_mux;

  // ==========================================================
  // apb slave: one wait state, answer registered
  assign access = psel && penable;
  assign done = access && pready;
  assign wr = done && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      if (access && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= (paddr > OFF_SER_STAT) || (paddr[1:0] != 2'b00);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_EVT_FLAG: rd_mux[LINK_W-1:0] = event_flag_reg;
      OFF_EVT_MASK: rd_mux = mask_reg;
      OFF_MISC: begin
        rd_mux[MISC_SER_EN_BIT] = route_reg.ser_en;
        rd_mux[MISC_CARD_SEL_BIT] = route_reg.card_sel;
        rd_mux[MISC_LINK_SEL_BIT] = route_reg.link_sel;
      end
      OFF_CARD_FLAG: rd_mux[CARD_W-1:0] = card_flag_reg;
      OFF_CARD_MASK: rd_mux[CARD_W-1:0] = card_mask_reg;
      OFF_SER_STAT: rd_mux[7:0] = {serial_irq_in, intb_in, inta_in, frame_reg == FRAME_LAST,
                                   state_reg, mode_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // control registers
  // mask write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= MASK_RESET;
      card_mask_reg <= '0;
    end else if (wr && paddr == OFF_EVT_MASK) begin
      mask_reg <= pwdata;
    end else if (wr && paddr == OFF_CARD_MASK) begin
      card_mask_reg <= pwdata[CARD_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_reg <= '{ser_en: MISC_RESET[MISC_SER_EN_BIT],
                     card_sel: MISC_RESET[MISC_CARD_SEL_BIT],
                     link_sel: MISC_RESET[MISC_LINK_SEL_BIT]};
    end else if (wr && paddr == OFF_MISC) begin
      route_reg <= '{ser_en: pwdata[MISC_SER_EN_BIT],
                     card_sel: pwdata[MISC_CARD_SEL_BIT],
                     link_sel: pwdata[MISC_LINK_SEL_BIT]};
    end
  end

  // pin function selects follow the serial enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multiuse_pin_zero_serial <= 1'b0;
      gpio_enable <= 1'b0;
      activity_led_zero_enable <= 1'b0;
    end else begin
      multiuse_pin_zero_serial <= route_reg.ser_en;
      gpio_enable <= route_reg.ser_en;
      activity_led_zero_enable <= route_reg.ser_en;
    end
  end

  // ==========================================================
  // event flags
  // clear side effect
  assign evt_clr = (wr && paddr == OFF_EVT_CLR) ? pwdata[LINK_W-1:0] : '0;
  assign card_clr = (wr && paddr == OFF_CARD_CLR) ? pwdata[CARD_W-1:0] : '0;

  irq_flag_bank #(.W(LINK_W)) u_link_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(link_evt),
    .clr(evt_clr),
    .flag_reg(event_flag_reg)
  );

  irq_flag_bank #(.W(CARD_W)) u_card_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(card_evt),
    .clr(card_clr),
    .flag_reg(card_flag_reg)
  );

  // ==========================================================
  // routing onto the two interrupt lines
  // mask gating
  assign link_pend = |(event_flag_reg & mask_reg[LINK_W-1:0]);
  assign card_pend = |(card_flag_reg & card_mask_reg);
  assign line_a = (link_pend && !route_reg.link_sel) || (card_pend && route_reg.card_sel);
  assign line_b = (link_pend && route_reg.link_sel) || (card_pend && !route_reg.card_sel);

  // the parallel pins are released while the serial link carries the lines
  // open drain only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inta_out <= 1'b0;
      intb_out <= 1'b0;
      inta_oe_n <= 1'b1;
      intb_oe_n <= 1'b1;
    end else begin
      inta_out <= 1'b0;
      intb_out <= 1'b0;
      inta_oe_n <= !(line_a && !route_reg.ser_en);
      intb_oe_n <= !(line_b && !route_reg.ser_en);
    end
  end

  // ==========================================================
  // serial line pulse measurement
  // clocks of pclk
  irq_pulse_meter #(.CW(4)) u_meter (
    .pclk(pclk),
    .presetn(presetn),
    .line_in(serial_irq_in),
    .low_cnt_reg(low_cnt),
    .pulse_end(pulse_end),
    .pulse_width(pulse_width)
  );

  assign start_ok = pulse_end && pulse_width >= START_MIN && pulse_width <= START_MAX;
  // quiet mode only starts a cycle when a line changed since the last one
  assign ser_req = {line_b, line_a} != sent_reg;

  // ==========================================================
  // serial cycle sequencer
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    frame_next = frame_reg;
    mode_next = mode_reg;
    if (!route_reg.ser_en) begin
      state_next = SER_IDLE;
    end else begin
      unique case (state_reg)
        SER_IDLE: begin
          if (start_ok) begin
            state_next = SER_FRAMES;
            phase_next = PH_T;
            frame_next = 6'h00;
          end else if (mode_reg == MODE_QUIET && ser_req && serial_irq_in) begin
            state_next = SER_START_DRV;
          end
        end
        SER_START_DRV: state_next = SER_START_WAIT;
        SER_START_WAIT: begin
          if (pulse_end) begin
            state_next = SER_FRAMES;
            phase_next = PH_T;
            frame_next = 6'h00;
          end
        end
        SER_FRAMES: begin
          if (pulse_end && pulse_width >= STOP_QUIET) begin
            state_next = SER_IDLE;
            mode_next = (pulse_width == STOP_QUIET) ? MODE_QUIET : MODE_CONT;
          end else begin
            unique case (phase_reg)
              PH_S: begin
                phase_next = PH_R;
                if (frame_reg != FRAME_LAST) begin
                  frame_next = frame_reg + 6'h01;
                end
              end
              PH_R: phase_next = PH_T;
              PH_T: phase_next = PH_S;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SER_IDLE;
      phase_reg <= PH_T;
      frame_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      frame_reg <= frame_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_CONT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // line levels reported in the cycle that just ended
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_reg <= 2'b00;
    end else if (state_reg == SER_FRAMES && state_next == SER_IDLE) begin
      sent_reg <= {line_b, line_a};
    end
  end

  // ==========================================================
  // serial line drive
  // lines after channel check
  always_comb begin
    unique case (frame_next)
      FRAME_INTA: own_pend = line_a;
      FRAME_INTB: own_pend = line_b;
      default: own_pend = 1'b0;
    endcase
  end

  assign drv_low_next = (state_next == SER_START_DRV) ||
                        (state_next == SER_FRAMES && phase_next == PH_S && own_pend);
  assign drv_high_next = state_next == SER_FRAMES && phase_next == PH_R &&
                         !serial_irq_oe_n && !serial_irq_out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_irq_out <= 1'b1;
      serial_irq_oe_n <= 1'b1;
    end else begin
      serial_irq_out <= !drv_low_next;
      serial_irq_oe_n <= !(drv_low_next || drv_high_next);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_quiet_start_one: assert property (
    state_reg == SER_START_DRV |-> !serial_irq_oe_n && !serial_irq_out ##1 serial_irq_oe_n)
    else $error("quiet start pulse not one clock");
  a_cont_no_start: assert property (
    mode_reg == MODE_CONT |-> state_reg != SER_START_DRV)
    else $error("device started a cycle in continuous mode");
  a_stop_mode_sel: assert property (
    route_reg.ser_en && state_reg == SER_FRAMES && pulse_end && pulse_width == STOP_QUIET
    |=> mode_reg == MODE_QUIET && state_reg == SER_IDLE)
    else $error("two clock stop did not select quiet mode");
  a_pci_open_drain: assert property (
    !inta_out && !intb_out)
    else $error("pci interrupt pin driven high");
  a_high_in_recovery: assert property (
    !serial_irq_oe_n && serial_irq_out |-> phase_reg == PH_R && $past(!serial_irq_out))
    else $error("serial line driven high outside recovery");
  a_frame_period: assert property (
    state_reg == SER_FRAMES && phase_reg == PH_S |-> ##3 (state_reg != SER_FRAMES ||
    phase_reg == PH_S))
    else $error("frame not three clocks");
  a_first_sample: assert property (
    route_reg.ser_en && state_reg == SER_IDLE && start_ok |-> ##2 (phase_reg == PH_S &&
    frame_reg == 6'h00) or ##2 (state_reg != SER_FRAMES))
    else $error("first sample not two clocks after start");
  a_intx_after_chk: assert property (
    state_reg == SER_FRAMES && !serial_irq_oe_n && !serial_irq_out |-> frame_reg >= FRAME_INTA)
    else $error("pci frame driven before channel check");
  a_route_sel: assert property (
    !route_reg.ser_en && link_pend && !route_reg.link_sel |=> !inta_oe_n)
    else $error("link interrupt not on line a");

  c_quiet_start: cover property (state_reg == SER_START_DRV);
  c_stop_quiet: cover property (state_reg == SER_FRAMES ##1 mode_reg == MODE_QUIET);
  c_inta_frame: cover property (frame_reg == FRAME_INTA && !serial_irq_oe_n);

endmodule

/* File: tb/irq_host_model.sv */
// Host side of the serialized interrupt link: starts cycles, samples INTA/INTB frames, stops.
// Assumes the bench resolves the wired-or line with a pull-up and feeds it back as line.
`timescale 1ns/10ps
module irq_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // resolved line and requests from the bench
  input wire logic line,
  input wire logic go,
  input wire logic [3:0] start_w,
  input wire logic [3:0] stop_w,
  // host drive and results
  output logic drv_n,
  output logic done,
  output logic got_a,
  output logic got_b
);
  logic [6:0] k;
  logic [3:0] left;
  logic [1:0] ph;

  // ==========================================================
  // cycle sequencer
  // start, frames, stop in clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_n <= 1'b1;
      done <= 1'b0;
      got_a <= 1'b0;
      got_b <= 1'b0;
      k <= '0;
      left <= '0;
      ph <= '0;
    end else begin
      done <= 1'b0;
      case (ph)
        2'd0: begin
          if (go) begin
            drv_n <= 1'b0;
            left <= start_w - 4'h1;
            ph <= 2'd1;
          end else if (!line && drv_n) begin
            // device opened with one clock; stretch to the full width
            drv_n <= 1'b0;
            left <= start_w - 4'h2;
            ph <= 2'd1;
          end
        end
        2'd1: begin
          if (left == 4'h0) begin
            drv_n <= 1'b1;
            k <= '0;
            got_a <= 1'b0;
            got_b <= 1'b0;
            ph <= 2'd2;
          end else begin
            left <= left - 4'h1;
          end
        end
        2'd2: begin
          k <= k + 7'h1;
          // a one-clock window either side tolerates the sample edge choice
          if (k >= 7'd52 && k <= 7'd54 && !line) got_a <= 1'b1;
          if (k >= 7'd55 && k <= 7'd57 && !line) got_b <= 1'b1;
          if (k == 7'd65) begin
            drv_n <= 1'b0;
            left <= stop_w - 4'h1;
            ph <= 2'd3;
          end
        end
        default: begin
          if (left == 4'h0) begin
            drv_n <= 1'b1;
            done <= 1'b1;
            ph <= 2'd0;
          end else begin
            left <= left - 4'h1;
          end
        end
      endcase
    end
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for irq_top: APB register traffic, PCI pin routing, serial link cycles.
// Assumes pull-ups on the PCI pins and the serial line; the host model is the far side.
`timescale 1ns/10ps
module testbench
  import irq_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, link_evt;
  irq_card_evt_t [3:0] card_evt;
  logic inta_out, inta_oe_n, intb_out, intb_oe_n, inta, intb;
  logic serial_irq_out, serial_irq_oe_n, ser_line, mux_sel, gpio_en, led_en;
  logic host_n, go, done, got_a, got_b;
  logic [3:0] start_w, stop_w;
  logic [33:0] aq[$];
  logic [1:0] sq[$];
  int errors, cmp_count, seed, idx, ck, n;

  // ==========================================================
  // wires and instances
  // open-drain pins and wired-or line
  assign inta = !inta_oe_n ? inta_out : 1'b1;
  assign intb = !intb_oe_n ? intb_out : 1'b1;
  assign ser_line = !host_n ? 1'b0 : (!serial_irq_oe_n ? serial_irq_out : 1'b1);

  irq_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_evt(link_evt), .card_evt(card_evt), .inta_in(inta),
    .inta_out(inta_out), .inta_oe_n(inta_oe_n), .intb_in(intb), .intb_out(intb_out),
    .intb_oe_n(intb_oe_n), .serial_irq_in(ser_line), .serial_irq_out(serial_irq_out),
    .serial_irq_oe_n(serial_irq_oe_n), .multiuse_pin_zero_serial(mux_sel),
    .gpio_enable(gpio_en), .activity_led_zero_enable(led_en));

  irq_host_model host (.pclk(pclk), .presetn(presetn), .line(ser_line), .go(go),
    .start_w(start_w), .stop_w(stop_w), .drv_n(host_n), .done(done), .got_a(got_a),
    .got_b(got_b));

  // ==========================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // status word: serial line idle high, pin levels, mode bit
  function automatic logic [31:0] st(input logic m, input logic a, input logic b);
    return {25'h0, 1'b1, b, a, 3'h0, m};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic se);
    int t;
    aq.push_back({!w, se, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ser(input logic hs, input logic [3:0] sw, input logic [3:0] pw,
      input logic [1:0] e);
    sq.push_back(e);
    start_w <= sw;
    stop_w <= pw;
    go <= hs;
    @(posedge pclk);
    go <= 1'b0;
    repeat (200) if (done !== 1'b1) @(posedge pclk);
  endtask

  // ==========================================================
  // result monitor
  always @(posedge pclk) begin
    logic [33:0] e;
    if (pready === 1'b1 && aq.size() > 0) begin
      e = aq.pop_front();
      check("pslverr", pslverr, e[32]);
      if (e[33]) check("prdata", prdata, e[31:0]);
    end
    if (done === 1'b1 && sq.size() > 0) check("frames", {got_a, got_b}, sq.pop_front());
    if (!inta_oe_n || !intb_oe_n) check("pci_drive", {inta_out, intb_out}, 0);
  end

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    #2_000_000;
    errors++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 98756;
    {psel, penable, pwrite, go} = '0;
    paddr = '0;
    pwdata = '0;
    link_evt = '0;
    card_evt = '0;
    start_w = 4'h4;
    stop_w = 4'h2;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_EVT_MASK, 32'h0000_0000, 0);
    apb(0, OFF_MISC, 32'h0000_0000, 0);
    apb(0, OFF_SER_STAT, st(0, 1, 1), 0);
    apb(0, 8'h20, 32'h0000_0000, 1);
    apb(0, 8'h02, 32'h0000_0000, 1);
    apb(1, OFF_EVT_FLAG, 32'hffff_ffff, 0);
    apb(0, OFF_EVT_FLAG, 32'h0000_0000, 0);
    for (int r = 0; r < 2; r++) begin
      idx = $unsigned($random(seed)) % 32;
      @(posedge pclk) link_evt <= 32'h0000_0001 << idx;
      @(posedge pclk) link_evt <= '0;
      apb(0, OFF_EVT_FLAG, 32'h0000_0001 << idx, 0);
      apb(0, OFF_SER_STAT, st(0, 1, 1), 0);
      apb(1, OFF_EVT_MASK, 32'h0000_0001 << idx, 0);
      apb(1, OFF_MISC, r ? 32'h0000_0002 : 32'h0000_0000, 0);
      apb(0, OFF_SER_STAT, st(0, r, !r), 0);
      apb(1, OFF_EVT_CLR, 32'h0000_0001 << idx, 0);
      apb(0, OFF_EVT_FLAG, 32'h0000_0000, 0);
      apb(0, OFF_SER_STAT, st(0, 1, 1), 0);
    end
    for (int kd = 0; kd < 3; kd++) begin
      ck = $unsigned($random(seed)) % 4;
      @(posedge pclk) card_evt[ck] <= irq_card_evt_t'(3'h4 >> kd);
      @(posedge pclk) card_evt <= '0;
      apb(0, OFF_CARD_FLAG, 32'h0000_0001 << (3 * ck + 2 - kd), 0);
      apb(1, OFF_CARD_MASK, 32'h0000_0fff, 0);
      apb(1, OFF_MISC, kd == 1 ? 32'h0200_0000 : 32'h0000_0000, 0);
      apb(0, OFF_SER_STAT, kd == 1 ? st(0, 0, 1) : st(0, 1, 0), 0);
      apb(1, OFF_CARD_CLR, 32'h0000_0fff, 0);
      apb(0, OFF_CARD_FLAG, 32'h0000_0000, 0);
    end
    // serial link: link event pending on the INTA frame
    @(posedge pclk) link_evt <= 32'hffff_ffff;
    @(posedge pclk) link_evt <= '0;
    apb(1, OFF_MISC, 32'h2000_0000, 0);
    apb(0, OFF_SER_STAT, st(0, 1, 1), 0);
    check("pin_select", {mux_sel, gpio_en, led_en}, 3'h7);
    n = 0;
    repeat (40) begin
      @(posedge pclk);
      if (serial_irq_oe_n !== 1'b1) n++;
    end
    check("self_start", n, 0);
    ser(1, 4'h4, 4'h3, 2'h2);
    ser(1, 4'h3, 4'h3, 2'h0);
    ser(1, 4'h8, 4'h2, 2'h2);
    apb(0, OFF_SER_STAT, st(1, 1, 1), 0);
    @(posedge pclk) card_evt[0] <= irq_card_evt_t'(3'h4);
    @(posedge pclk) card_evt <= '0;
    ser(0, 4'h4, 4'h3, 2'h3);
    apb(0, OFF_SER_STAT, st(0, 1, 1), 0);
    repeat (5) @(posedge pclk);
    wrap_up();
  end
endmodule
